// file: dv/custom_logic_unit_properties.sv
// Checker for the custom logic unit, bound to its top module.
// Assumes single-cycle Wishbone masters that hold a request until ack.
`timescale 1ns/1ps
module custom_logic_unit_checker
  import logic_unit_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              arst_n,
  // Register bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  // Outputs
  input wire logic [1:0]        tableOutputEvent,
  input wire logic [1:0]        tableOutPin,
  input wire logic [1:0]        tableOutPinOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ------------------------------------------------------------
  // Shadow of the global control byte
  // ------------------------------------------------------------
  logic       take;
  logic [3:0] idx;
  logic       globalEn_reg;
  logic       standby_reg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx  = wb_adr_i[5:2];
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      globalEn_reg <= 1'b0;
      standby_reg  <= 1'b0;
    end
    else if (take && wb_we_i && wb_sel_i[0] && idx == IDX_GLOBAL_CONTROL)
    begin
      globalEn_reg <= wb_dat_i[GC_ENABLE_BIT];
      standby_reg  <= wb_dat_i[GC_STANDBY_BIT];
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_ACK_NEXT: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(take))
    else $error("ack without a request");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && (idx inside {[4'h2:4'h4]}
    || idx > 4'hC) |-> wb_dat_o == DATA_ZERO)
    else $error("unmapped read not zero");
  AST_GC_READ: assert property (wb_ack_o && !wb_we_i && idx == IDX_GLOBAL_CONTROL
    |-> wb_dat_o[7:0] == {1'b0, standby_reg, 5'b00000, globalEn_reg})
    else $error("global control readback wrong");
  AST_DISABLED_QUIET: assert property (!globalEn_reg [*2]
    |-> tableOutputEvent == 2'b00 && tableOutPinOe == 2'b00)
    else $error("output active while unit disabled");
  AST_PIN_GATED: assert property ((tableOutPin & ~tableOutPinOe) == 2'b00)
    else $error("pin driven high without enable");
endmodule : custom_logic_unit_checker

bind custom_logic_unit custom_logic_unit_checker u_checker (.clk, .arst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .tableOutputEvent, .tableOutPin, .tableOutPinOe);

// file: dv/custom_logic_unit_tb_top.sv
// Self-checking bench for the custom logic unit.
// Assumes the unit acks one cycle after a request and outputs settle in 12 cycles.
`timescale 1ns/1ps
module custom_logic_unit_tb_top
  import logic_unit_pkg::*;
;
  logic              clk, arst_n, cyc, stb, wbWe, ack, evA, evB;
  logic [ADDR_W-1:0] adr;
  logic [3:0]        sel, periphReq, periphIn, mode;
  logic [DATA_W-1:0] wdat, rdat, rd;
  logic [5:0]        pinReq, tableInPin;
  logic [1:0]        eventReq, outEvent, outPin, outOe;
  int                n_mismatch, checks_done, cnt;
  localparam logic [7:0] TRUTH_A = 8'hB4;
  logic [3:0]        modes [4] = '{SEQ_DFF, SEQ_JK, SEQ_GATED_LATCH_MODE, SEQ_RS};

  custom_logic_unit uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wbWe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tableInPin(tableInPin), .eventInputA(evA), .eventInputB(evB),
    .periphIn(periphIn), .tableOutputEvent(outEvent), .tableOutPin(outPin),
    .tableOutPinOe(outOe));
  logic_partner u_partner (.clk(clk), .arst_n(arst_n), .pinReq(pinReq),
    .eventReq(eventReq), .periphReq(periphReq), .tableInPin(tableInPin),
    .eventInputA(evA), .eventInputB(evB), .periphIn(periphIn));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int t;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    wbWe <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h00_0000, d};
    t = 0;
    do
    begin
      @(posedge clk);
      t++;
    end
    while (ack !== 1'b1 && t < 40);
    rd = rdat;
    if (t >= 40)
    begin
      n_mismatch++;
      conclude();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task automatic rdChk(input logic [3:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(rd, {24'h00_0000, exp});
  endtask : rdChk
  task automatic drive(input logic [5:0] p, input logic e, input logic [3:0] q);
    @(posedge clk);
    pinReq    <= p;
    eventReq  <= {1'b0, e};
    periphReq <= q;
    repeat (12) @(posedge clk);
  endtask : drive
  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // Clock, watchdog, sequence
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    {arst_n, cyc, stb, wbWe, adr, wdat, pinReq, eventReq, periphReq} = '0;
    sel = 4'hF;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 16; i++) rdChk(i[3:0], 8'h00);
    wr(IDX_GLOBAL_CONTROL, 8'h41);
    rdChk(IDX_GLOBAL_CONTROL, 8'h41);
    wr(4'h2, 8'hFF);
    rdChk(4'h2, 8'h00);
    // Inputs: peripheral, event A, pin
    wr(4'h6, 8'h36);
    wr(4'h7, 8'h05);
    wr(4'h8, TRUTH_A);
    wr(4'h5, 8'h09);
    for (int v = 0; v < 8; v++)
    begin
      drive({3'b000, v[2], 2'b00}, v[1], {3'b000, v[0]});
      check(outEvent[0], TRUTH_A[v]);
      check(outPin[0], TRUTH_A[v]);
    end
    wr(4'h6, 8'h00);
    rdChk(4'h6, 8'h36);
    wr(4'h5, 8'h00);
    rdChk(4'h5, 8'h08);
    // Unit off while the clock source moves
    wr(IDX_GLOBAL_CONTROL, 8'h00);
    wr(4'h5, 8'h49);
    wr(IDX_GLOBAL_CONTROL, 8'h01);
    drive(6'h00, 1'b0, 4'h1);
    drive(6'h04, 1'b0, 4'h1);
    check(outEvent[0], TRUTH_A[1]);
    // Pair feeding the sequential element
    wr(4'h8, 8'hAA);
    wr(4'hA, 8'h06);
    wr(4'hC, 8'hAA);
    wr(4'h9, 8'h01);
    foreach (modes[m])
    begin
      mode = modes[m];
      drive(6'h00, 1'b0, 4'h0);
      wr(IDX_GLOBAL_CONTROL, 8'h00);
      wr(4'h5, 8'h00);
      wr(IDX_SEQ_CONTROL, {4'h0, mode});
      wr(4'h5, 8'h01);
      wr(IDX_GLOBAL_CONTROL, 8'h01);
      wr(IDX_SEQ_CONTROL, 8'h00);
      rdChk(IDX_SEQ_CONTROL, {4'h0, mode});
      drive(6'h00, 1'b0, 4'h0);
      check(outEvent[0], 1'b0);
      drive(6'h00, 1'b0, (mode == SEQ_JK || mode == SEQ_RS) ? 4'h1 : 4'h5);
      check(outEvent[0], 1'b1);
      drive(6'h00, 1'b0, 4'h0);
      check(outEvent[0], 1'b1);
      drive(6'h00, 1'b0, 4'h4);
      check(outEvent[0], 1'b0);
    end
    // Edge pulse through the synchroniser
    drive(6'h00, 1'b0, 4'h0);
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h91);
    drive(6'h00, 1'b0, 4'h0);
    @(posedge clk);
    periphReq <= 4'h4;
    cnt = 0;
    repeat (16) @(posedge clk) if (outEvent[1] === 1'b1) cnt++;
    check(cnt, 1);
    // Filter delay from the launching edge
    wr(4'h9, 8'h00);
    wr(4'h9, 8'h21);
    drive(6'h00, 1'b0, 4'h0);
    periphReq <= 4'h4;
    cnt = 0;
    while (outEvent[1] !== 1'b1 && cnt < 20)
    begin
      @(posedge clk);
      cnt++;
    end
    check(cnt >= 5 && cnt <= 8, 1);
    wr(4'h9, 8'h00);
    drive(6'h00, 1'b0, 4'h4);
    check(outEvent[1], 1'b0);
    conclude();
  end
endmodule : custom_logic_unit_tb_top

// file: dv/logic_partner.sv
// Pins, event network and peripherals feeding the logic unit.
// Assumes the bench asks for line levels; each is launched on a clock edge.
`timescale 1ns/1ps
module logic_partner (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Requests from the bench
  input  wire logic [5:0] pinReq,
  input  wire logic [1:0] eventReq,
  input  wire logic [3:0] periphReq,
  // Lines into the unit
  output logic      [5:0] tableInPin,
  output logic            eventInputA,
  output logic            eventInputB,
  output logic      [3:0] periphIn
);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tableInPin  <= 6'h00;
      eventInputA <= 1'b0;
      eventInputB <= 1'b0;
      periphIn    <= 4'h0;
    end
    else
    begin
      tableInPin  <= pinReq;
      eventInputA <= eventReq[0];
      eventInputB <= eventReq[1];
      periphIn    <= periphReq;
    end
  end
endmodule : logic_partner

// file: src/custom_logic_unit.sv
// Custom logic unit: two three-input look-up tables, one sequential element,
// registers on a classic Wishbone slave.
// Assumes pins and event lines are asynchronous to clk; peripheral lines are
// already in clk's domain.
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module custom_logic_unit
  import logic_unit_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // Table input pins, three per table, table n at bits 3n+2..3n
  input  wire logic [5:0]        tableInPin,
  // Event lines from the event network
  input  wire logic              eventInputA,
  input  wire logic              eventInputB,
  // Peripheral lines, two per table, table n at bits 2n+1..2n
  input  wire logic [3:0]        periphIn,
  // Outputs
  output logic [1:0]             tableOutputEvent,
  output logic [1:0]             tableOutPin,
  output logic [1:0]             tableOutPinOe
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0]  asyncIn;
  logic [7:0]  sync1_reg;
  logic [7:0]  sync2_reg;
  logic [7:0]  sync3_reg;
  logic [7:0]  syncStable_reg;
  logic        ack_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic        globalEnable_reg;
  logic        runStandby_reg;
  logic [3:0]  seqSelect_reg;
  logic [REG_W-1:0] global_control_reg [NUM_TABLES];
  logic [REG_W-1:0] ctrlB_reg [NUM_TABLES];
  logic [REG_W-1:0] ctrlC_reg [NUM_TABLES];
  logic [REG_W-1:0] truth_reg [NUM_TABLES];
  logic        directOut_reg [NUM_TABLES];
  logic        in2Prev_reg [NUM_TABLES];
  logic        seqOut_reg;
  logic [1:0]  outEvent_reg;
  logic [1:0]  outPin_reg;
  logic [1:0]  outPinOe_reg;
  logic        wbReq;
  logic        wbWrite;
  logic [3:0]  regIdx;
  logic [REG_W-1:0] wrByte;
  logic [REG_W-1:0] rdByte;
  logic        tableOn [NUM_TABLES];
  logic        tick [NUM_TABLES];
  logic        rawOut [NUM_TABLES];
  logic        stage [NUM_TABLES];
  logic        in2Raw [NUM_TABLES];
  logic [2:0]  lutIdx [NUM_TABLES];
  logic        finalOut [NUM_TABLES];

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic pick_input(
    input logic [3:0] sel,
    input logic       feedback,
    input logic       link,
    input logic       evA,
    input logic       evB,
    input logic       pin,
    input logic       pA,
    input logic       pB
  );
    logic v;
    v = 1'b0;
    case (sel)
      INSRC_FEEDBACK: v = feedback;
      INSRC_LINK:     v = link;
      INSRC_EVENT_A:  v = evA;
      INSRC_EVENT_B:  v = evB;
      INSRC_IO:       v = pin;
      INSRC_PERIPH_A: v = pA;
      INSRC_PERIPH_B: v = pB;
      default:        v = 1'b0;
    endcase
    return v;
  endfunction : pick_input

  function automatic logic [3:0] table_index(input int n, input logic [3:0] ofs);
    return 4'(IDX_TABLE_BASE + 4'(n) * IDX_TABLE_STRIDE + ofs);
  endfunction : table_index

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  assign asyncIn = {eventInputB, eventInputA, tableInPin};

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_reg      <= BYTE_ZERO;
      sync2_reg      <= BYTE_ZERO;
      sync3_reg      <= BYTE_ZERO;
      syncStable_reg <= BYTE_ZERO;
    end
    else
    begin
      sync1_reg      <= asyncIn;
      sync2_reg      <= sync1_reg;
      sync3_reg      <= sync2_reg;
      // Accept a change only once stages two and three agree
      syncStable_reg <= (~(sync2_reg ^ sync3_reg) & sync3_reg)
                      | ((sync2_reg ^ sync3_reg) & syncStable_reg);
    end
  end

  // ------------------------------------------------------------
  // Wishbone decode
  // ------------------------------------------------------------
  assign wbReq   = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wbWrite = wbReq & wb_we_i & wb_sel_i[0];
  assign regIdx  = wb_adr_i[ADDR_W-1:IDX_LSB];
  assign wrByte  = wb_dat_i[REG_W-1:0];

  always_comb
  begin
    rdByte = BYTE_ZERO;
    if (regIdx == IDX_GLOBAL_CONTROL)
    begin
      rdByte[GC_ENABLE_BIT]  = globalEnable_reg;
      rdByte[GC_STANDBY_BIT] = runStandby_reg;
    end
    else if (regIdx == IDX_SEQ_CONTROL)
    begin
      rdByte[SEQ_SEL_LSB +: 4] = seqSelect_reg;
    end
    for (int n = 0; n < NUM_TABLES; n++)
    begin
      if (regIdx == table_index(n, IDX_OFS_CTRL_A)) rdByte = global_control_reg[n];
      if (regIdx == table_index(n, IDX_OFS_CTRL_B)) rdByte = ctrlB_reg[n];
      if (regIdx == table_index(n, IDX_OFS_CTRL_C)) rdByte = ctrlC_reg[n];
      if (regIdx == table_index(n, IDX_OFS_TRUTH))  rdByte = truth_reg[n];
    end
  end

  // One wait state; unmapped reads give zero, unmapped writes vanish
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= DATA_ZERO;
    end
    else
    begin
      ack_reg   <= wbReq;
      rdata_reg <= {{(DATA_W-REG_W){1'b0}}, rdByte};
    end
  end

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // global enable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      globalEnable_reg <= 1'b0;
      runStandby_reg   <= 1'b0;
    end
    else if (wbWrite && regIdx == IDX_GLOBAL_CONTROL)
    begin
      globalEnable_reg <= wrByte[GC_ENABLE_BIT];
      runStandby_reg   <= wrByte[GC_STANDBY_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seqSelect_reg <= SEQ_DISABLE;
    end
    else if (wbWrite && regIdx == IDX_SEQ_CONTROL && !global_control_reg[0][TA_ENABLE_BIT])
    begin
      seqSelect_reg <= wrByte[SEQ_SEL_LSB +: 4];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int n = 0; n < NUM_TABLES; n++)
      begin
        global_control_reg[n] <= BYTE_ZERO;
        ctrlB_reg[n] <= BYTE_ZERO;
        ctrlC_reg[n] <= BYTE_ZERO;
        truth_reg[n] <= BYTE_ZERO;
      end
    end
    else if (wbWrite)
    begin
      for (int n = 0; n < NUM_TABLES; n++)
      begin
        if (regIdx == table_index(n, IDX_OFS_CTRL_A))
        begin
          // Fields land only from the disabled state, with or without enabling
          if (!global_control_reg[n][TA_ENABLE_BIT])
          begin
            global_control_reg[n] <= wrByte;
          end
          else
          begin
            global_control_reg[n][TA_ENABLE_BIT] <= wrByte[TA_ENABLE_BIT];
          end
        end
        if (regIdx == table_index(n, IDX_OFS_CTRL_B) && !global_control_reg[n][TA_ENABLE_BIT])
        begin
          ctrlB_reg[n] <= wrByte;
        end
        if (regIdx == table_index(n, IDX_OFS_CTRL_C) && !global_control_reg[n][TA_ENABLE_BIT])
        begin
          ctrlC_reg[n] <= wrByte;
        end
        if (regIdx == table_index(n, IDX_OFS_TRUTH))
        begin
          truth_reg[n] <= wrByte;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Look-up tables
  // ------------------------------------------------------------
  for (genvar n = 0; n < NUM_TABLES; n++)
  begin : g_table
    logic linkSrc;
    logic in0;
    logic in1;
    logic in2Eff;

    assign linkSrc = directOut_reg[(n + 1) % NUM_TABLES];

    assign tableOn[n] = globalEnable_reg & global_control_reg[n][TA_ENABLE_BIT];

    assign in0 = pick_input(ctrlB_reg[n][TB_IN0_LSB +: 4], seqOut_reg, linkSrc,
                            syncStable_reg[6], syncStable_reg[7], syncStable_reg[3*n],
                            periphIn[2*n], periphIn[2*n+1]);
    assign in1 = pick_input(ctrlB_reg[n][TB_IN1_LSB +: 4], seqOut_reg, linkSrc,
                            syncStable_reg[6], syncStable_reg[7], syncStable_reg[3*n+1],
                            periphIn[2*n], periphIn[2*n+1]);
    assign in2Raw[n] = pick_input(ctrlC_reg[n][TC_IN2_LSB +: 4], seqOut_reg, linkSrc,
                                  syncStable_reg[6], syncStable_reg[7],
                                  syncStable_reg[3*n+2], periphIn[2*n], periphIn[2*n+1]);

    assign in2Eff = global_control_reg[n][TA_CLOCK_SOURCE_SELECT_BIT] ? 1'b0 : in2Raw[n];

    assign lutIdx[n] = {in2Eff, in1, in0};
    assign rawOut[n] = tableOn[n] & truth_reg[n][lutIdx[n]];

    assign tick[n] = global_control_reg[n][TA_CLOCK_SOURCE_SELECT_BIT] ? (in2Raw[n] & ~in2Prev_reg[n]) : 1'b1;

    table_filter u_filter (
      .clk          (clk),
      .arst_n       (arst_n),
      .enable       (tableOn[n]),
      .tick         (tick[n]),
      .filterSelect (global_control_reg[n][TA_FILT_LSB +: 2]),
      .edgeEnable   (global_control_reg[n][TA_EDGE_BIT]),
      .lutValue     (rawOut[n]),
      .stageOut     (stage[n])
    );
  end : g_table

  // Link taps a registered copy so two linked tables cannot form a loop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int n = 0; n < NUM_TABLES; n++)
      begin
        directOut_reg[n] <= 1'b0;
        in2Prev_reg[n]   <= 1'b0;
      end
    end
    else
    begin
      for (int n = 0; n < NUM_TABLES; n++)
      begin
        directOut_reg[n] <= rawOut[n];
        in2Prev_reg[n]   <= in2Raw[n];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequential element
  // ------------------------------------------------------------
  // mode per select
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seqOut_reg <= 1'b0;
    end
    else if (!tableOn[0])
    begin
      seqOut_reg <= 1'b0;
    end
    else
    begin
      case (seqSelect_reg)
        SEQ_DFF:
        begin
          if (tick[0] && stage[1])
          begin
            seqOut_reg <= stage[0];
          end
        end
        SEQ_JK:
        begin
          if (tick[0])
          begin
            case ({stage[0], stage[1]})
              2'b01:   seqOut_reg <= 1'b0;
              2'b10:   seqOut_reg <= 1'b1;
              2'b11:   seqOut_reg <= ~seqOut_reg;
              default: seqOut_reg <= seqOut_reg;
            endcase
          end
        end
        SEQ_GATED_LATCH_MODE:
        begin
          if (stage[1])
          begin
            seqOut_reg <= stage[0];
          end
        end
        SEQ_RS:
        begin
          if (stage[0] && !stage[1])
          begin
            seqOut_reg <= 1'b1;
          end
          else if (!stage[0] && stage[1])
          begin
            seqOut_reg <= 1'b0;
          end
        end
        default: seqOut_reg <= 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Even table carries the sequencer once a mode is chosen
  assign finalOut[0] = (seqSelect_reg == SEQ_DISABLE) ? stage[0] : seqOut_reg;
  assign finalOut[1] = stage[1];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      outEvent_reg <= 2'b00;
      outPin_reg   <= 2'b00;
      outPinOe_reg <= 2'b00;
    end
    else
    begin
      for (int n = 0; n < NUM_TABLES; n++)
      begin
        outEvent_reg[n] <= tableOn[n] & finalOut[n];
        outPin_reg[n]   <= tableOn[n] & finalOut[n] & global_control_reg[n][TA_OUTEN_BIT];
        outPinOe_reg[n] <= tableOn[n] & global_control_reg[n][TA_OUTEN_BIT];
      end
    end
  end

  assign wb_ack_o         = ack_reg;
  assign wb_dat_o         = rdata_reg;
  assign tableOutputEvent = outEvent_reg;
  assign tableOutPin      = outPin_reg;
  assign tableOutPinOe    = outPinOe_reg;

endmodule : custom_logic_unit

// file: src/logic_unit_pkg.sv
// Constants shared by the custom logic unit: register map, fields, encodings.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
package logic_unit_pkg;

  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int          NUM_TABLES     = 2;
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 32;
  localparam int          REG_W          = 8;
  localparam int          IDX_LSB        = 2;
  localparam logic [31:0] DATA_ZERO      = 32'h0000_0000;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;

  // ------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [3:0]  IDX_GLOBAL_CONTROL = 4'h0;
  localparam logic [3:0]  IDX_SEQ_CONTROL    = 4'h1;
  localparam logic [3:0]  IDX_TABLE_BASE     = 4'h5;
  localparam logic [3:0]  IDX_TABLE_STRIDE   = 4'h4;
  localparam logic [3:0]  IDX_OFS_CTRL_A     = 4'h0;
  localparam logic [3:0]  IDX_OFS_CTRL_B     = 4'h1;
  localparam logic [3:0]  IDX_OFS_CTRL_C     = 4'h2;
  localparam logic [3:0]  IDX_OFS_TRUTH      = 4'h3;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int          GC_ENABLE_BIT  = 0;
  localparam int          GC_STANDBY_BIT = 6;
  localparam int          TA_ENABLE_BIT  = 0;
  localparam int          TA_OUTEN_BIT   = 3;
  localparam int          TA_FILT_LSB    = 4;
  localparam int          TA_CLOCK_SOURCE_SELECT_BIT  = 6;
  localparam int          TA_EDGE_BIT    = 7;
  localparam int          TB_IN0_LSB     = 0;
  localparam int          TB_IN1_LSB     = 4;
  localparam int          TC_IN2_LSB     = 0;
  localparam int          SEQ_SEL_LSB    = 0;

  // ------------------------------------------------------------
  // Encodings
  // ------------------------------------------------------------
  localparam logic [3:0]  SEQ_DISABLE    = 4'h0;
  localparam logic [3:0]  SEQ_DFF        = 4'h1;
  localparam logic [3:0]  SEQ_JK         = 4'h2;
  localparam logic [3:0]  SEQ_GATED_LATCH_MODE     = 4'h3;
  localparam logic [3:0]  SEQ_RS         = 4'h4;

  localparam logic [1:0]  FILT_NONE      = 2'h0;
  localparam logic [1:0]  FILT_SYNC      = 2'h1;
  localparam logic [1:0]  FILT_FILTER    = 2'h2;

  localparam logic [3:0]  INSRC_MASK     = 4'h0;
  localparam logic [3:0]  INSRC_FEEDBACK = 4'h1;
  localparam logic [3:0]  INSRC_LINK     = 4'h2;
  localparam logic [3:0]  INSRC_EVENT_A  = 4'h3;
  localparam logic [3:0]  INSRC_EVENT_B  = 4'h4;
  localparam logic [3:0]  INSRC_IO       = 4'h5;
  localparam logic [3:0]  INSRC_PERIPH_A = 4'h6;
  localparam logic [3:0]  INSRC_PERIPH_B = 4'h7;

endpackage : logic_unit_pkg

// file: src/table_filter.sv
// Output conditioning of one look-up table: synchroniser, filter, edge detector.
// Assumes tick marks the edges of the table's selected clock, in clk's domain.
`timescale 1ns/1ps
module table_filter
  import logic_unit_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [1:0] filterSelect,
  input  wire logic       edgeEnable,
  // Data
  input  wire logic       lutValue,
  output logic            stageOut
);

  logic sample1_reg;
  logic sample2_reg;
  logic sample3_reg;
  logic filt_reg;
  logic edgePrev_reg;
  logic filtered;

  // ------------------------------------------------------------
  // Sample chain
  // ------------------------------------------------------------
  // cleared when disabled
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample1_reg <= 1'b0;
      sample2_reg <= 1'b0;
      sample3_reg <= 1'b0;
      filt_reg    <= 1'b0;
    end
    else if (!enable)
    begin
      sample1_reg <= 1'b0;
      sample2_reg <= 1'b0;
      sample3_reg <= 1'b0;
      filt_reg    <= 1'b0;
    end
    else if (tick)
    begin
      sample1_reg <= lutValue;
      sample2_reg <= sample1_reg;
      sample3_reg <= sample2_reg;
      // Spike shorter than two ticks never reaches the output
      if (sample2_reg == sample3_reg)
      begin
        filt_reg <= sample3_reg;
      end
    end
  end

  always_comb
  begin
    case (filterSelect)
      FILT_NONE:   filtered = lutValue;
      FILT_SYNC:   filtered = sample2_reg;
      FILT_FILTER: filtered = filt_reg;
      default:     filtered = lutValue;
    endcase
  end

  // ------------------------------------------------------------
  // Edge detector
  // ------------------------------------------------------------
  // edge state cleared
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      edgePrev_reg <= 1'b0;
    end
    else if (!enable)
    begin
      edgePrev_reg <= 1'b0;
    end
    else if (tick)
    begin
      edgePrev_reg <= filtered;
    end
  end

  assign stageOut = edgeEnable ? (filtered & ~edgePrev_reg) : filtered;

endmodule : table_filter
